// *** verilog/pst_pkg.sv ***
// constants and types shared by the program sequencer block
package pst_pkg;
    // widths and stack depth
    localparam int PC_W    = 11;
    localparam int WORD_W  = 15;
    localparam int DEPTH   = 4;
    // data memory offsets of the registers kept here
    localparam logic [7:0] TBL_PTR_LOW_OFF  = 8'h07;
    localparam logic [7:0] TBL_HIGH_OFF     = 8'h08;
    localparam logic [7:0] TBL_PTR_HIGH_OFF = 8'h1F;
    localparam logic [7:0] PC_LOW_OFF       = 8'h06;
    // reset values
    localparam logic [10:0] PC_RESET        = 11'h000;
    localparam logic [7:0]  TBL_PTR_LOW_RST = 8'h00;
    localparam logic [7:0]  TBL_PTR_HI_RST  = 8'h00;
    localparam logic [7:0]  TBL_HIGH_RST    = 8'h00;
    // vectors
    localparam logic [10:0] SERIAL_VEC      = 11'h004;
    localparam logic [10:0] TIMER_VEC       = 11'h008;
    // last page high bits for the last-page table read
    localparam logic [2:0]  LAST_PAGE       = 3'h7;
    // phase of the instruction cycle that ends it, and table capture phase
    localparam logic [1:0]  PHASE_LAST      = 2'h3;
    localparam logic [1:0]  PHASE_CAPTURE   = 2'h1;
    // instruction class presented by the core decoder
    typedef enum logic [2:0] {
        PLAIN_OP,
        SKIP_OP,
        JUMP_OP,
        CALL_OP,
        RETURN_OP,
        RETURN_FROM_INTERRUPT_OP,
        TABLE_READ_CURRENT_PAGE,
        TABLE_READ_LAST_PAGE
    } pst_op_type;
endpackage

// *** verilog/pst_sequencer.sv ***
// program counter, return stack, interrupt vectoring and table reads
`timescale 1ns/1ps
module pst_sequencer #(
    parameter bit HIGH_PTR_EN = 1'b0
) (
    input  wire logic                    MCLK,
    input  wire logic                    RST,
    input  wire logic                    CE,
    input  wire pst_pkg::pst_op_type     OP,
    input  wire logic [10:0]             OP_ADDR,
    input  wire logic [7:0]              OP_DEST,
    input  wire logic [14:0]             PM_DATA,
    input  wire logic [7:0]              DM_ADDR,
    input  wire logic                    DM_WE,
    input  wire logic [7:0]              DM_WDATA,
    input  wire logic                    SER_DONE,
    input  wire logic                    TMR_OVF,
    input  wire logic                    SER_IE,
    input  wire logic                    TMR_IE,
    input  wire logic                    INT_EN,
    output logic      [10:0]             PM_ADDR,
    output logic      [1:0]              PHASE,
    output logic                         EXEC_VALID,
    output logic      [7:0]              DM_RDATA,
    output logic                         TBL_WE,
    output logic      [7:0]              TBL_WADDR,
    output logic      [7:0]              TBL_WDATA,
    output logic                         INT_ACK,
    output logic                         SER_FLAG,
    output logic                         TMR_FLAG,
    output logic                         STACK_FULL
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // address match on the data memory bus
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // pc step, wraps inside the 2K space
    function automatic logic [10:0] step(input logic [10:0] p);
        return p + 11'h001;
    endfunction

    typedef enum {ST_RUN, ST_DUMMY, ST_TABLE} pst_state_type;

    pst_state_type state;
    pst_state_type next_state;
    logic [10:0]   pc;
    logic [10:0]   next_pc;
    logic [1:0]    phase;
    logic [10:0]   stk [pst_pkg::DEPTH];
    logic [1:0]    stack_index;
    logic [2:0]    depth;
    logic [7:0]    table_pointer_low;
    logic [7:0]    table_pointer_high;
    logic [7:0]    table_high_byte;
    logic [7:0]    tbl_dest;
    logic          pcl_pend;
    logic [7:0]    pcl_val;
    logic          cyc_end;
    logic          cap_edge;
    logic          full;
    logic          int_req;
    logic          take_int;
    logic          take_ser;
    logic          do_push;
    logic          do_pop;
    logic          pcl_now;
    logic [7:0]    pcl_data;
    logic [10:0]   stack_top;
    logic [10:0]   next_tbl;

    // ----------------------------------------------------------------
    // phase counter
    // ----------------------------------------------------------------
    // four phases make one instruction cycle
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            phase <= 2'h0;
        end else if (CE) begin
            phase <= phase + 2'h1;
        end
    end

    assign cyc_end  = CE && (phase == pst_pkg::PHASE_LAST);
    assign cap_edge = CE && (phase == pst_pkg::PHASE_CAPTURE);
    assign full     = (depth == 3'(pst_pkg::DEPTH));
    // wrapped index gives the top, also when empty or overflowed
    assign stack_top = stk[stack_index - 2'h1];
    assign pcl_now   = DM_WE && hit(DM_ADDR, pst_pkg::PC_LOW_OFF);
    assign pcl_data  = pcl_now ? DM_WDATA : pcl_val;
    // a full stack holds the request back until a return
    assign int_req = INT_EN && !full &&
                     ((SER_FLAG && SER_IE) || (TMR_FLAG && TMR_IE));

    // ----------------------------------------------------------------
    // next pc and sequencing decision
    // ----------------------------------------------------------------
    // decided once per instruction cycle, at its last phase
    always_comb begin
        next_pc    = pc;
        next_state = state;
        do_push    = 1'b0;
        do_pop     = 1'b0;
        take_int   = 1'b0;
        take_ser   = 1'b0;
        if (cyc_end) begin
            case (state)
                ST_RUN: begin
                    if (pcl_pend || pcl_now) begin
                        next_pc    = {pc[10:8], pcl_data};
                        next_state = ST_DUMMY;
                    end else begin
                        case (OP)
                            pst_pkg::SKIP_OP: begin
                                // fetched word dropped, dummy refills
                                next_pc    = step(pc);
                                next_state = ST_DUMMY;
                            end
                            pst_pkg::JUMP_OP: begin
                                next_pc    = OP_ADDR;
                                next_state = ST_DUMMY;
                            end
                            pst_pkg::CALL_OP: begin
                                // no full check: overflow is allowed
                                do_push    = 1'b1;
                                next_pc    = OP_ADDR;
                                next_state = ST_DUMMY;
                            end
                            pst_pkg::RETURN_OP,
                            pst_pkg::RETURN_FROM_INTERRUPT_OP: begin
                                do_pop     = 1'b1;
                                next_pc    = stack_top;
                                next_state = ST_DUMMY;
                            end
                            pst_pkg::TABLE_READ_CURRENT_PAGE,
                            pst_pkg::TABLE_READ_LAST_PAGE: begin
                                next_state = ST_TABLE;
                            end
                            default: begin
                                if (int_req) begin
                                    take_int   = 1'b1;
                                    take_ser   = SER_FLAG && SER_IE;
                                    do_push    = 1'b1;
                                    next_pc    = take_ser ?
                                                 pst_pkg::SERIAL_VEC :
                                                 pst_pkg::TIMER_VEC;
                                    next_state = ST_DUMMY;
                                end else begin
                                    next_pc = step(pc);
                                end
                            end
                        endcase
                    end
                end
                ST_DUMMY: begin
                    next_pc    = step(pc);
                    next_state = ST_RUN;
                end
                ST_TABLE: begin
                    next_pc    = step(pc);
                    next_state = ST_RUN;
                end
                default: begin
                    next_state = ST_RUN;
                end
            endcase
        end
    end

    // table address from the pointer and the selected page bits
    always_comb begin
        if (OP == pst_pkg::TABLE_READ_LAST_PAGE) begin
            next_tbl = {pst_pkg::LAST_PAGE, table_pointer_low};
        end else if (HIGH_PTR_EN) begin
            next_tbl = {table_pointer_high[2:0], table_pointer_low};
        end else begin
            next_tbl = {pc[10:8], table_pointer_low};
        end
    end

    // ----------------------------------------------------------------
    // program counter and state
    // ----------------------------------------------------------------
    // reset starts execution at the reset vector
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pc    <= pst_pkg::PC_RESET;
            state <= ST_RUN;
        end else if (CE) begin
            pc    <= next_pc;
            state <= next_state;
        end
    end

    // fetch address: table word during a table cycle, else the pc
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            PM_ADDR    <= pst_pkg::PC_RESET;
            EXEC_VALID <= 1'b0;
        end else if (cyc_end) begin
            PM_ADDR    <= (next_state == ST_TABLE) ? next_tbl : next_pc;
            EXEC_VALID <= (next_state == ST_RUN);
        end else if (cap_edge && state == ST_TABLE) begin
            PM_ADDR    <= pc; // resume the instruction prefetch
        end
    end

    // phase shown to the core for decode timing
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            PHASE <= 2'h0;
        end else if (CE) begin
            PHASE <= phase + 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // return stack
    // ----------------------------------------------------------------
    // index wraps; an overflowing push overwrites the oldest entry
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            stack_index <= 2'h0;
            depth       <= 3'h0;
        end else if (do_push) begin
            stack_index <= stack_index + 2'h1;
            depth       <= full ? depth : depth + 3'h1;
        end else if (do_pop) begin
            stack_index <= stack_index - 2'h1;
            depth       <= (depth == 3'h0) ? depth : depth - 3'h1;
        end
    end

    // entries hold pc values only, no data memory path reaches them
    always_ff @(posedge MCLK) begin
        if (do_push) begin
            stk[stack_index] <= pc;
        end
    end

    // full flag for the core; interrupts are held off meanwhile
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            STACK_FULL <= 1'b0;
        end else if (CE) begin
            STACK_FULL <= do_push ? (depth >= 3'h3) :
                          do_pop  ? 1'b0 : full;
        end
    end

    // ----------------------------------------------------------------
    // interrupt flags and acknowledge
    // ----------------------------------------------------------------
    // a new event in the acknowledge cycle wins over the clear
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            SER_FLAG <= 1'b0;
            TMR_FLAG <= 1'b0;
        end else if (CE) begin
            if (SER_DONE) begin
                SER_FLAG <= 1'b1;
            end else if (take_int && take_ser) begin
                SER_FLAG <= 1'b0;
            end
            if (TMR_OVF) begin
                TMR_FLAG <= 1'b1;
            end else if (take_int && !take_ser) begin
                TMR_FLAG <= 1'b0;
            end
        end
    end

    // one-cycle acknowledge pulse per serviced request
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            INT_ACK <= 1'b0;
        end else if (CE) begin
            INT_ACK <= take_int;
        end
    end

    // ----------------------------------------------------------------
    // registers on the data memory bus
    // ----------------------------------------------------------------
    // pointer writes; the high byte register ignores every write
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            table_pointer_low  <= pst_pkg::TBL_PTR_LOW_RST;
            table_pointer_high <= pst_pkg::TBL_PTR_HI_RST;
        end else if (CE && DM_WE) begin
            if (hit(DM_ADDR, pst_pkg::TBL_PTR_LOW_OFF)) begin
                table_pointer_low <= DM_WDATA;
            end
            if (hit(DM_ADDR, pst_pkg::TBL_PTR_HIGH_OFF)) begin
                table_pointer_high <= DM_WDATA;
            end
        end
    end

    // pc low byte write is held until the cycle decision
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pcl_pend <= 1'b0;
            pcl_val  <= 8'h00;
        end else if (CE) begin
            if (cyc_end) begin
                pcl_pend <= 1'b0;
            end else if (pcl_now && state == ST_RUN) begin
                pcl_pend <= 1'b1;
                pcl_val  <= DM_WDATA;
            end
        end
    end

    // read data registered; unmapped addresses answer zero
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            DM_RDATA <= 8'h00;
        end else if (CE) begin
            if (hit(DM_ADDR, pst_pkg::PC_LOW_OFF)) begin
                DM_RDATA <= pc[7:0];
            end else if (hit(DM_ADDR, pst_pkg::TBL_PTR_LOW_OFF)) begin
                DM_RDATA <= table_pointer_low;
            end else if (hit(DM_ADDR, pst_pkg::TBL_PTR_HIGH_OFF)) begin
                DM_RDATA <= table_pointer_high;
            end else if (hit(DM_ADDR, pst_pkg::TBL_HIGH_OFF)) begin
                DM_RDATA <= table_high_byte;
            end else begin
                DM_RDATA <= 8'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // table read path
    // ----------------------------------------------------------------
    // destination captured with the table instruction; the address is
    // taken straight from the decision so the page select sees its own op
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            tbl_dest <= 8'h00;
        end else if (CE && state == ST_RUN) begin
            tbl_dest <= OP_DEST;
        end
    end

    // word split: low byte out, bits 14..8 kept, bit 7 reads zero
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            table_high_byte <= pst_pkg::TBL_HIGH_RST;
            TBL_WE          <= 1'b0;
            TBL_WADDR       <= 8'h00;
            TBL_WDATA       <= 8'h00;
        end else if (CE) begin
            TBL_WE <= 1'b0;
            if (cap_edge && state == ST_TABLE) begin
                table_high_byte <= {1'b0, PM_DATA[14:8]};
                TBL_WE          <= 1'b1;
                TBL_WADDR       <= tbl_dest;
                TBL_WDATA       <= PM_DATA[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    logic plain_end;
    assign plain_end = cyc_end && state == ST_RUN && !pcl_pend && !pcl_now;

    pc_step_a: assert property (
        plain_end && OP == pst_pkg::PLAIN_OP && !int_req
        |=> pc == $past(pc) + 11'h001)
        else $error("pc did not advance by one");

    skip_two_a: assert property (
        plain_end && OP == pst_pkg::SKIP_OP
        |=> state == ST_DUMMY ##1 (state == ST_DUMMY)[*3]
        ##1 pc == $past(pc, 5) + 11'h002)
        else $error("skip did not move pc by two");

    pcl_page_a: assert property (
        cyc_end && state == ST_RUN && (pcl_pend || pcl_now)
        |=> pc[10:8] == $past(pc[10:8]) && state == ST_DUMMY)
        else $error("low byte branch left the page");

    jump_load_a: assert property (
        plain_end && OP == pst_pkg::JUMP_OP
        |=> pc == $past(OP_ADDR) && state == ST_DUMMY)
        else $error("jump target not loaded");

    ret_pop_a: assert property (
        plain_end && OP == pst_pkg::RETURN_OP
        |=> pc == $past(stack_top)
        && stack_index == $past(stack_index) - 2'h1)
        else $error("return did not pop the stack");

    full_hold_a: assert property (
        full && !do_pop |=> !INT_ACK)
        else $error("acknowledge with a full stack");

    vector_a: assert property (
        INT_ACK |-> pc == pst_pkg::SERIAL_VEC || pc == pst_pkg::TIMER_VEC)
        else $error("interrupt went to a wrong vector");

    high_ro_a: assert property (
        !(cap_edge && state == ST_TABLE)
        |=> table_high_byte == $past(table_high_byte))
        else $error("table high byte changed without a table read");

    table_two_a: assert property (
        plain_end && (OP == pst_pkg::TABLE_READ_CURRENT_PAGE
        || OP == pst_pkg::TABLE_READ_LAST_PAGE) && CE
        |=> state == ST_TABLE ##2 TBL_WE)
        else $error("table read did not take a second cycle");

endmodule

// *** verif/pst_pm_model.sv ***
// program memory model that answers fetch and table addresses
`timescale 1ns/1ps
module pst_pm_model (
    input  wire logic [10:0] addr,
    output logic      [14:0] data
);
    // each word mixes its own address bits, so a wrong table address
    // shows in the low byte, the high bits or both of what comes back
    assign data = {addr[6:0], addr[10:3]};
endmodule

// *** verif/tb_pst_sequencer.sv ***
// self-checking bench for the program sequencer and its table reads
`timescale 1ns/1ps
module tb_pst_sequencer;
    // ------------------------------------------------------------------
    // signals, design and program memory
    // ------------------------------------------------------------------
    logic                mclk = 1'b0;
    logic                rst = 1'b1;
    pst_pkg::pst_op_type op = pst_pkg::PLAIN_OP;
    pst_pkg::pst_op_type tops [2];
    logic [10:0]         op_addr = 11'h000;
    logic [10:0]         pm_addr, p, v, e;
    logic [10:0]         q [4];
    logic [7:0]          op_dest = 8'h41;
    logic [7:0]          dm_addr = 8'h00;
    logic [7:0]          dm_wdata = 8'h00;
    logic [7:0]          dm_rdata, tbl_waddr, tbl_wdata;
    logic [14:0]         pm_data;
    logic [1:0]          phase;
    logic                dm_we = 1'b0;
    logic                ce = 1'b1;
    logic                int_en = 1'b1;
    logic                ser_done = 1'b0;
    logic                tmr_ovf = 1'b0;
    logic                exec_valid, tbl_we, int_ack;
    logic                ser_flag, tmr_flag, stack_full;
    int                  mismatches = 0;
    int                  n_checks = 0;
    int                  cycles = 0;

    always #4 mclk = ~mclk;

    pst_sequencer u_pst_sequencer (
        .MCLK(mclk), .RST(rst), .CE(ce), .OP(op), .OP_ADDR(op_addr),
        .OP_DEST(op_dest), .PM_DATA(pm_data), .DM_ADDR(dm_addr),
        .DM_WE(dm_we), .DM_WDATA(dm_wdata), .SER_DONE(ser_done),
        .TMR_OVF(tmr_ovf), .SER_IE(1'b1), .TMR_IE(1'b1), .INT_EN(int_en),
        .PM_ADDR(pm_addr), .PHASE(phase), .EXEC_VALID(exec_valid),
        .DM_RDATA(dm_rdata), .TBL_WE(tbl_we), .TBL_WADDR(tbl_waddr),
        .TBL_WDATA(tbl_wdata), .INT_ACK(int_ack), .SER_FLAG(ser_flag),
        .TMR_FLAG(tmr_flag), .STACK_FULL(stack_full));
    pst_pm_model u_pst_pm_model (.addr(pm_addr), .data(pm_data));

    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // op is held only over the cycle end of an executing cycle
    task automatic run(input pst_pkg::pst_op_type o, input logic [10:0] a);
        for (int n = 0; n < 32 && !(phase === 2'h2 && exec_valid); n++) begin
            @(negedge mclk);
        end
        p = pm_addr;
        @(posedge mclk) op <= o;
        op_addr <= a;
        @(posedge mclk) op <= pst_pkg::PLAIN_OP;
        @(negedge mclk);
    endtask
    task automatic sync();
        @(negedge mclk);
        for (int n = 0; n < 16 && exec_valid !== 1'b1; n++) @(negedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) dm_addr <= a;
        dm_we <= 1'b1;
        dm_wdata <= d;
        @(posedge mclk) dm_we <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge mclk) dm_addr <= a;
        @(posedge mclk);
        @(negedge mclk) chk({3'h0, dm_rdata}, {3'h0, x});
    endtask
    task automatic kick(input logic ser);
        @(posedge mclk) ser_done <= ser;
        tmr_ovf <= ~ser;
        @(posedge mclk) ser_done <= 1'b0;
        tmr_ovf <= 1'b0;
        @(negedge mclk);
    endtask
    // v keeps the pc seen just before the vector was loaded
    task automatic take(input logic [10:0] vec);
        for (int n = 0; n < 24 && int_ack !== 1'b1; n++) begin
            if (pm_addr !== vec) v = pm_addr;
            @(negedge mclk);
        end
        chk({10'h0, int_ack}, 11'h001);
        chk(pm_addr, vec);
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        tops[0] = pst_pkg::TABLE_READ_CURRENT_PAGE;
        tops[1] = pst_pkg::TABLE_READ_LAST_PAGE;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk(pm_addr, pst_pkg::PC_RESET);
        chk({10'h0, stack_full}, 11'h000);
        rd(pst_pkg::TBL_PTR_LOW_OFF, pst_pkg::TBL_PTR_LOW_RST);
        rd(8'h55, 8'h00);
        e = {9'h0, phase};
        repeat (3) begin
            @(negedge mclk);
            e = e + 11'h001;
            chk({9'h0, phase}, {9'h0, e[1:0]});
        end
        // clock enable low must freeze the phase count
        @(posedge mclk) ce <= 1'b0;
        @(negedge mclk) e = {9'h0, phase};
        repeat (3) @(negedge mclk);
        chk({9'h0, phase}, e);
        @(posedge mclk) ce <= 1'b1;
        $display("test reset done");
        run(pst_pkg::PLAIN_OP, 11'h000);
        chk(pm_addr, p + 11'h001);
        run(pst_pkg::JUMP_OP, 11'h5a3);
        chk(pm_addr, 11'h5a3);
        chk({10'h0, exec_valid}, 11'h000);
        sync();
        chk(pm_addr, 11'h5a4);
        run(pst_pkg::SKIP_OP, 11'h000);
        chk({10'h0, exec_valid}, 11'h000);
        sync();
        chk(pm_addr, p + 11'h002);
        wr(pst_pkg::PC_LOW_OFF, 8'h3c);
        run(pst_pkg::PLAIN_OP, 11'h000);
        chk(pm_addr, {p[10:8], 8'h3c});
        chk({10'h0, exec_valid}, 11'h000);
        sync();
        rd(pst_pkg::PC_LOW_OFF, 8'h3d);
        $display("test sequencing done");
        for (int i = 0; i < 4; i++) begin
            run(pst_pkg::CALL_OP, 11'(256 + 16 * i));
            q[i] = p;
            chk(pm_addr, 11'(256 + 16 * i));
            sync();
        end
        chk({10'h0, stack_full}, 11'h001);
        kick(1'b0);
        repeat (8) @(negedge mclk);
        chk({10'h0, tmr_flag}, 11'h001);
        chk({10'h0, int_ack}, 11'h000);
        run(pst_pkg::RETURN_OP, 11'h000);
        chk(pm_addr, q[3]);
        take(pst_pkg::TIMER_VEC);
        chk({10'h0, tmr_flag}, 11'h000);
        run(pst_pkg::RETURN_FROM_INTERRUPT_OP, 11'h000);
        chk(pm_addr, v);
        for (int i = 2; i >= 0; i--) begin
            run(pst_pkg::RETURN_OP, 11'h000);
            chk(pm_addr, q[i]);
        end
        kick(1'b1);
        chk({10'h0, ser_flag}, 11'h001);
        take(pst_pkg::SERIAL_VEC);
        chk({10'h0, ser_flag}, 11'h000);
        run(pst_pkg::RETURN_FROM_INTERRUPT_OP, 11'h000);
        chk(pm_addr, v);
        // with interrupts disabled the request waits, flag kept
        @(posedge mclk) int_en <= 1'b0;
        kick(1'b0);
        repeat (12) @(negedge mclk);
        chk({10'h0, tmr_flag}, 11'h001);
        @(posedge mclk) int_en <= 1'b1;
        take(pst_pkg::TIMER_VEC);
        run(pst_pkg::RETURN_FROM_INTERRUPT_OP, 11'h000);
        chk(pm_addr, v);
        $display("test stack and interrupts done");
        run(pst_pkg::JUMP_OP, 11'h2f0);
        wr(pst_pkg::TBL_PTR_LOW_OFF, 8'hc5);
        rd(pst_pkg::TBL_PTR_LOW_OFF, 8'hc5);
        for (int k = 0; k < 2; k++) begin
            run(tops[k], 11'h000);
            e = k ? {pst_pkg::LAST_PAGE, 8'hc5} : {p[10:8], 8'hc5};
            chk(pm_addr, e);
            for (int n = 0; n < 8 && tbl_we !== 1'b1; n++) @(negedge mclk);
            chk({10'h0, tbl_we}, 11'h001);
            chk({3'h0, tbl_waddr}, {3'h0, op_dest});
            chk({3'h0, tbl_wdata}, {3'h0, e[10:3]});
            sync();
            chk(pm_addr, p + 11'h001);
            rd(pst_pkg::TBL_HIGH_OFF, {1'b0, e[6:0]});
        end
        wr(pst_pkg::TBL_HIGH_OFF, 8'hff);
        rd(pst_pkg::TBL_HIGH_OFF, 8'h45);
        $display("test table reads done");
        wrap_up();
    end
endmodule
